// ---- src/cix_consts.svh ----
// Register offsets, field positions, reset values and fixed codes of the address decoder
`ifndef CIX_CONSTS_SVH
`define CIX_CONSTS_SVH
// ==========================================
// Register byte offsets
`define CIX_OFS_CTRL 8'h00
`define CIX_OFS_STATUS 8'h04
`define CIX_OFS_ACC 8'h08
`define CIX_OFS_INDEX_X 8'h0C
`define CIX_OFS_INDEX_Y 8'h10
`define CIX_OFS_STACK 8'h14
`define CIX_OFS_PC 8'h18
`define CIX_OFS_FLAGS 8'h1C
`define CIX_OFS_EA 8'h20
`define CIX_OFS_OPERAND 8'h24
// ==========================================
// Control fields
`define CIX_CTRL_START 0
`define CIX_CTRL_MODE_LSB 1
`define CIX_CTRL_COND_LSB 4
// ==========================================
// Flag register bit positions
`define CIX_FLG_C 0
`define CIX_FLG_V 1
`define CIX_FLG_Z 2
`define CIX_FLG_N 3
`define CIX_FLG_I 4
`define CIX_FLG_H 5
`define CIX_FLG_X 6
`define CIX_FLG_S 7
// ==========================================
// Reset values and fixed codes
`define CIX_FLAGS_RST 8'hD0
`define CIX_WORD_RST 16'h0000
`define CIX_PAGE2_PREFIX 8'h18
`define CIX_DIRECT_PAGE 8'h00
`endif

// ---- src/cix_pkg.sv ----
// Types shared by the address decoder
`default_nettype none
package cix_pkg;
  // Addressing mode requested by software
  typedef enum logic [2:0] {
    inherent_mode, immediate_mode, immediate_wide_mode, direct_mode,
    extended_mode, relative_mode, relative_wide_mode, indexed_mode
  } cix_mode_e;
  // Indexed sub-mode found in the index postbyte
  typedef enum logic [2:0] {
    indexed_short_mode, indexed_auto_mode, indexed_accumulator_mode, indexed_nine_bit_mode,
    indexed_sixteen_bit_mode, indexed_indirect_constant_mode, indexed_indirect_accumulator_mode
  } cix_ixkind_e;
  typedef enum logic [2:0] {
    st_idle, st_wait_queue, st_opcode, st_postbyte, st_ext, st_calc, st_ind_hi, st_ind_lo
  } cix_state_e;
endpackage
`default_nettype wire

// ---- src/cix_addr_decode.sv ----
// Programming model, instruction queue and addressing-mode decoder with APB access
`default_nettype none
`include "cix_consts.svh"

module cix_addr_decode #(
  parameter int QDEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Memory system, byte reads
  output logic mem_req_o,
  output logic [15:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic [7:0] mem_rdata_i,
  // Decode status
  output logic busy_o,
  output logic [15:0] ea_o
);
  import cix_pkg::*;

  // ==========================================
  // Elaboration checks
  // Fewer than three slots could never let an instruction start
  if (QDEPTH < 3 || QDEPTH > 16) begin : g_bad_depth
    $error("QDEPTH must be 3 to 16");
  end

  localparam int QW = $clog2(QDEPTH);

  // ==========================================
  // Functions
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] sext8(input logic [7:0] v);
    sext8 = {{8{v[7]}}, v};
  endfunction

  function automatic logic [QW-1:0] qnext(input logic [QW-1:0] p);
    qnext = (32'(p) == QDEPTH - 1) ? '0 : QW'(p + 1'b1);
  endfunction

  // Branch condition over N Z V C
  function automatic logic cond_true(input logic [3:0] c, input logic [7:0] f);
    logic n;
    logic z;
    logic v;
    logic k;
    logic r;
    n = f[`CIX_FLG_N];
    z = f[`CIX_FLG_Z];
    v = f[`CIX_FLG_V];
    k = f[`CIX_FLG_C];
    case (c[3:1])
      3'h0: r = 1'b1;
      3'h1: r = ~(k | z);
      3'h2: r = ~k;
      3'h3: r = ~z;
      3'h4: r = ~v;
      3'h5: r = ~n;
      3'h6: r = ~(n ^ v);
      default: r = ~(z | (n ^ v));
    endcase
    cond_true = c[0] ? ~r : r;
  endfunction

  // ==========================================
  // State
  cix_state_e state;
  cix_mode_e mode;
  logic [3:0] cond;
  logic [7:0] acc_a;
  logic [7:0] acc_b;
  logic [15:0] index_x;
  logic [15:0] index_y;
  logic [15:0] stack_pointer;
  logic [15:0] pc;
  logic [7:0] flag_register;
  logic [15:0] ea;
  logic [15:0] operand;
  logic [7:0] opcode;
  logic [7:0] index_postbyte;
  logic [15:0] ext_word;
  logic [1:0] ext_left;
  logic [7:0] ptr_hi;
  logic done;
  logic page2;
  logic taken;
  logic indirect;
  logic [7:0] q_mem [QDEPTH];
  logic [QW-1:0] q_rd;
  logic [QW-1:0] q_wr;
  logic [QW:0] q_count;
  logic [15:0] fetch_addr;
  logic bus_busy;
  logic bus_data;
  logic discard;

  // ==========================================
  // APB decode
  wire logic setup = psel_i & ~penable_i;
  wire logic access = psel_i & penable_i;
  wire logic idle = (state == st_idle);
  wire logic hit_ctrl = (paddr_i == `CIX_OFS_CTRL);
  wire logic hit_acc = (paddr_i == `CIX_OFS_ACC);
  wire logic hit_x = (paddr_i == `CIX_OFS_INDEX_X);
  wire logic hit_y = (paddr_i == `CIX_OFS_INDEX_Y);
  wire logic hit_stack = (paddr_i == `CIX_OFS_STACK);
  wire logic hit_pc = (paddr_i == `CIX_OFS_PC);
  wire logic hit_flags = (paddr_i == `CIX_OFS_FLAGS);
  wire logic hit_rw = hit_ctrl | hit_acc | hit_x | hit_y | hit_stack | hit_pc | hit_flags;
  wire logic hit_ro = (paddr_i == `CIX_OFS_STATUS) | (paddr_i == `CIX_OFS_EA) |
                      (paddr_i == `CIX_OFS_OPERAND);
  // Only the decoder may change the model registers while a decode runs, so bus writes then are refused
  wire logic wr_ok = pwrite_i ? (hit_rw & idle) : (hit_rw | hit_ro);
  wire logic wr = access & pwrite_i & wr_ok;
  wire logic start = wr & hit_ctrl & pstrb_i[0] & pwdata_i[`CIX_CTRL_START];
  wire logic pc_wr = wr & hit_pc;
  wire logic [15:0] status = {opcode, 1'b0, indirect, taken, page2, done, busy_o, 2'b00};
  logic [31:0] next_prdata;
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr_i)
      `CIX_OFS_CTRL: next_prdata = {24'h000000, cond, mode, 1'b0};
      `CIX_OFS_STATUS: next_prdata = {16'h0000, status};
      `CIX_OFS_ACC: next_prdata = {16'h0000, acc_a, acc_b};
      `CIX_OFS_INDEX_X: next_prdata = {16'h0000, index_x};
      `CIX_OFS_INDEX_Y: next_prdata = {16'h0000, index_y};
      `CIX_OFS_STACK: next_prdata = {16'h0000, stack_pointer};
      `CIX_OFS_PC: next_prdata = {16'h0000, pc};
      `CIX_OFS_FLAGS: next_prdata = {24'h000000, flag_register};
      `CIX_OFS_EA: next_prdata = {16'h0000, ea};
      `CIX_OFS_OPERAND: next_prdata = {16'h0000, operand};
      default: next_prdata = 32'h0000_0000;
    endcase
  end
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~wr_ok;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (setup) begin
      prdata_o <= next_prdata;
    end
  end

  // ==========================================
  // Instruction queue and memory port
  wire logic q_empty = (q_count == '0);
  wire logic [7:0] q_byte = q_mem[q_rd];
  wire logic need_byte = (state == st_opcode) | (state == st_postbyte) | (state == st_ext);
  wire logic pop = need_byte & ~q_empty;
  wire logic want_data = (state == st_ind_hi) | (state == st_ind_lo);
  wire logic ack_fetch = bus_busy & mem_ack_i & ~bus_data;
  wire logic ack_data = bus_busy & mem_ack_i & bus_data;
  wire logic push = ack_fetch & ~discard & ~pc_wr;
  wire logic issue_data = ~bus_busy & want_data;
  // Prefetch keeps running beside decode so bytes are ready for the next start
  wire logic issue_fetch = ~bus_busy & ~want_data & ~pc_wr & (32'(q_count) < QDEPTH);
  assign mem_req_o = bus_busy;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      bus_busy <= 1'b0;
      bus_data <= 1'b0;
      mem_addr_o <= `CIX_WORD_RST;
    end else if (issue_data | issue_fetch) begin
      bus_busy <= 1'b1;
      bus_data <= issue_data;
      mem_addr_o <= issue_data ? ((state == st_ind_hi) ? ea : ea + 16'h0001) : fetch_addr;
    end else if (mem_ack_i) begin
      bus_busy <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      discard <= 1'b0;
      fetch_addr <= `CIX_WORD_RST;
    end else if (pc_wr) begin
      // A fetch already on the bus belongs to the old stream
      discard <= bus_busy & ~bus_data & ~mem_ack_i;
      fetch_addr <= wmerge(pc, pwdata_i, pstrb_i);
    end else begin
      if (ack_fetch) begin
        discard <= 1'b0;
      end
      if (issue_fetch) begin
        fetch_addr <= fetch_addr + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      q_mem[q_wr] <= mem_rdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || pc_wr) begin
      q_rd <= '0;
      q_wr <= '0;
      q_count <= '0;
    end else begin
      q_rd <= pop ? qnext(q_rd) : q_rd;
      q_wr <= push ? qnext(q_wr) : q_wr;
      q_count <= q_count + (QW + 1)'(push) - (QW + 1)'(pop);
    end
  end

  // ==========================================
  // Index postbyte decode
  wire logic [7:0] pb = index_postbyte;
  wire logic grp111 = (pb[7:5] == 3'b111);
  wire logic is_short = ~pb[5];
  wire logic is_auto = pb[5] & ~grp111;
  wire logic is_accum = grp111 & pb[2];
  wire logic is_ind = grp111 & (pb[1:0] == 2'b11);
  wire logic [1:0] rr = grp111 ? pb[4:3] : pb[7:6];
  // Counter never reaches auto step: rr=11 with p-bit set is the 111 group
  wire logic [15:0] base = (rr == 2'b00) ? index_x : (rr == 2'b01) ? index_y :
                           (rr == 2'b10) ? stack_pointer : pc;
  wire logic [15:0] acc_d = {acc_a, acc_b};
  wire logic [15:0] step = pb[3] ? {12'hFFF, pb[3:0]} : {12'h000, pb[3:0]} + 16'h0001;
  wire logic [15:0] short_off = {{11{pb[4]}}, pb[4:0]};
  wire logic [15:0] const_off = pb[1] ? ext_word : {{8{pb[0]}}, ext_word[7:0]};
  wire logic [15:0] acc_off = (pb[1:0] == 2'b00) ? {8'h00, acc_a} :
                              (pb[1:0] == 2'b01) ? {8'h00, acc_b} : acc_d;
  wire logic [15:0] idx_off = is_short ? short_off : is_auto ? (pb[4] ? 16'h0000 : step) :
                              is_accum ? acc_off : const_off;
  wire logic [15:0] idx_ea = base + idx_off;
  wire logic [1:0] post_ext = (~grp111 | pb[2]) ? 2'd0 : (pb[1] ? 2'd2 : 2'd1);
  cix_ixkind_e ixkind;
  assign ixkind = is_short ? indexed_short_mode : is_auto ? indexed_auto_mode :
                  is_accum ? (pb[1:0] == 2'b11 ? indexed_indirect_accumulator_mode : indexed_accumulator_mode) :
                  ~pb[1] ? indexed_nine_bit_mode :
                  pb[0] ? indexed_indirect_constant_mode : indexed_sixteen_bit_mode;

  // ==========================================
  // Mode decode
  wire logic [1:0] mode_ext = (mode == immediate_mode || mode == direct_mode || mode == relative_mode) ? 2'd1 :
                              (mode == immediate_wide_mode || mode == extended_mode ||
                               mode == relative_wide_mode) ? 2'd2 : 2'd0;
  logic [15:0] next_ea;
  always_comb begin
    next_ea = ea;
    case (mode)
      direct_mode: next_ea = {`CIX_DIRECT_PAGE, ext_word[7:0]};
      extended_mode: next_ea = ext_word;
      relative_mode: next_ea = pc + sext8(ext_word[7:0]);
      relative_wide_mode: next_ea = pc + ext_word;
      indexed_mode: next_ea = idx_ea;
      default: next_ea = ea;
    endcase
  end

  // ==========================================
  // Sequencer
  wire logic [1:0] ctl_next_ext = (state == st_opcode) ? mode_ext : post_ext;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= st_idle;
      mode <= inherent_mode;
      cond <= 4'h0;
      opcode <= 8'h00;
      index_postbyte <= 8'h00;
      ext_word <= `CIX_WORD_RST;
      ext_left <= 2'd0;
      ea <= `CIX_WORD_RST;
      operand <= `CIX_WORD_RST;
      ptr_hi <= 8'h00;
      done <= 1'b0;
      page2 <= 1'b0;
      taken <= 1'b0;
      indirect <= 1'b0;
    end else begin
      case (state)
        st_idle: begin
          if (wr & hit_ctrl & pstrb_i[0]) begin
            mode <= cix_mode_e'(pwdata_i[`CIX_CTRL_MODE_LSB +: 3]);
            cond <= pwdata_i[`CIX_CTRL_COND_LSB +: 4];
          end
          if (start) begin
            state <= st_wait_queue;
            done <= 1'b0;
            page2 <= 1'b0;
            taken <= 1'b0;
            indirect <= 1'b0;
            ext_word <= `CIX_WORD_RST;
          end
        end
        st_wait_queue: begin
          if (32'(q_count) >= 3) begin
            state <= st_opcode;
          end
        end
        st_opcode: begin
          if (pop) begin
            if (q_byte == `CIX_PAGE2_PREFIX && !page2) begin
              page2 <= 1'b1;
            end else begin
              opcode <= q_byte;
              ext_left <= ctl_next_ext;
              state <= (mode == indexed_mode) ? st_postbyte : (mode_ext == 2'd0) ? st_calc : st_ext;
            end
          end
        end
        st_postbyte: begin
          if (pop) begin
            index_postbyte <= q_byte;
            ext_left <= (~q_byte[5] | (q_byte[7:5] != 3'b111) | q_byte[2]) ? 2'd0 :
                        (q_byte[1] ? 2'd2 : 2'd1);
            state <= ((q_byte[7:5] == 3'b111) && !q_byte[2]) ? st_ext : st_calc;
          end
        end
        st_ext: begin
          if (pop) begin
            ext_word <= {ext_word[7:0], q_byte};
            ext_left <= ext_left - 2'd1;
            state <= (ext_left == 2'd1) ? st_calc : st_ext;
          end
        end
        st_calc: begin
          ea <= next_ea;
          if (mode == immediate_mode || mode == immediate_wide_mode) begin
            operand <= ext_word;
          end else if (mode == indexed_mode) begin
            operand <= {5'h00, ixkind, index_postbyte};
          end
          if (mode == relative_mode || mode == relative_wide_mode) begin
            taken <= cond_true(cond, flag_register);
          end
          if (mode == indexed_mode && is_ind) begin
            indirect <= 1'b1;
            state <= st_ind_hi;
          end else begin
            done <= 1'b1;
            state <= st_idle;
          end
        end
        st_ind_hi: begin
          if (ack_data) begin
            ptr_hi <= mem_rdata_i;
            state <= st_ind_lo;
          end
        end
        st_ind_lo: begin
          if (ack_data) begin
            ea <= {ptr_hi, mem_rdata_i};
            done <= 1'b1;
            state <= st_idle;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // ==========================================
  // Programming model
  wire logic auto_upd = (state == st_calc) && (mode == indexed_mode) && is_auto;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_a <= 8'h00;
      acc_b <= 8'h00;
      index_x <= `CIX_WORD_RST;
      index_y <= `CIX_WORD_RST;
      stack_pointer <= `CIX_WORD_RST;
      pc <= `CIX_WORD_RST;
      flag_register <= `CIX_FLAGS_RST;
    end else begin
      if (wr & hit_acc) begin
        {acc_a, acc_b} <= wmerge({acc_a, acc_b}, pwdata_i, pstrb_i);
      end
      if (wr & hit_x) begin
        index_x <= wmerge(index_x, pwdata_i, pstrb_i);
      end
      if (wr & hit_y) begin
        index_y <= wmerge(index_y, pwdata_i, pstrb_i);
      end
      if (wr & hit_stack) begin
        stack_pointer <= wmerge(stack_pointer, pwdata_i, pstrb_i);
      end
      if (wr & hit_flags & pstrb_i[0]) begin
        flag_register <= pwdata_i[7:0];
      end
      if (pc_wr) begin
        pc <= wmerge(pc, pwdata_i, pstrb_i);
      end else if (pop) begin
        pc <= pc + 16'h0001;
      end
      if (auto_upd) begin
        case (rr)
          2'b00: index_x <= base + step;
          2'b01: index_y <= base + step;
          default: stack_pointer <= base + step;
        endcase
      end
    end
  end

  assign busy_o = ~idle;
  assign ea_o = ea;
endmodule // cix_addr_decode
`default_nettype wire

// ---- bench/cix_addr_decode_assertions.sv ----
// Port-level checks of the address decoder
`default_nettype none
module cix_addr_decode_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // Memory and status
  input wire logic mem_req_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_ack_i,
  input wire logic busy_o,
  input wire logic [15:0] ea_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic acc = psel_i && penable_i;
  wire logic mapped = paddr_i <= 8'h24 && paddr_i[1:0] == 2'b00;
  // ==========================================
  // Bus and memory handshakes
  property p_ready; acc |-> pready_o; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  property p_unmapped; acc && !mapped |-> pslverr_o; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_read_ok; acc && !pwrite_i && mapped |-> !pslverr_o; endproperty
  a_read_ok: assert property (p_read_ok) else $error("mapped read refused");
  property p_busy_wr; acc && pwrite_i && busy_o && paddr_i <= 8'h1C |-> pslverr_o; endproperty
  a_busy_wr: assert property (p_busy_wr) else $error("write while busy accepted");
  property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("fetch address moved while pending");
  property p_gap; mem_ack_i |=> !mem_req_o; endproperty
  a_gap: assert property (p_gap) else $error("request not dropped after answer");
  // ==========================================
  // Decode run
  property p_reset; $fell(reset_i) |-> !busy_o && !mem_req_o && ea_o == 16'h0000; endproperty
  a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
  property p_start; acc && pwrite_i && paddr_i == 8'h00 && pstrb_i[0] && pwdata_i[0] && !busy_o |=> busy_o;
  endproperty
  a_start: assert property (p_start) else $error("start did not raise busy");
  property p_finish; $rose(busy_o) |-> ##[1:400] !busy_o; endproperty
  a_finish: assert property (p_finish) else $error("decode never finished");
  // Result may only change while a decode runs
  property p_ea_hold; !busy_o && $past(busy_o) == 1'b0 |-> $stable(ea_o); endproperty
  a_ea_hold: assert property (p_ea_hold) else $error("result moved while idle");
endmodule // cix_addr_decode_chk
bind cix_addr_decode cix_addr_decode_chk cix_addr_decode_chk_inst (.clk_i(clk_i), .reset_i(reset_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pstrb_i(pstrb_i), .pready_o(pready_o), .pslverr_o(pslverr_o), .mem_req_o(mem_req_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .busy_o(busy_o), .ea_o(ea_o));
`default_nettype wire

// ---- bench/cix_mem_model.sv ----
// Byte memory answering the decoder's code and pointer reads
`default_nettype none
module cix_mem_model (
  // Clock
  input wire logic clk_i,
  // Byte read port
  input wire logic mem_req_i,
  input wire logic [15:0] mem_addr_i,
  output logic mem_ack_o,
  output logic [7:0] mem_rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535] = '{default: 8'h00};
  int lat = 0;
  int wait_cnt = 0;
  initial mem_ack_o = 1'b0;
  initial mem_rdata_o = 8'h00;
  // ==========================================
  // One answer per request; released data toggles so a late sample never matches
  always @(posedge clk_i) begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (mem_req_i && !mem_ack_o) begin
      if (wait_cnt >= lat) begin
        mem_ack_o <= 1'b1;
        mem_rdata_o <= mem[mem_addr_i];
        wait_cnt <= 0;
      end else begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule // cix_mem_model
`default_nettype wire

// ---- bench/tb_cpu_indexed_address_decode.sv ----
// Self-checking bench for the addressing-mode decoder
`default_nettype none
`include "cix_consts.svh"
module tb_cpu_indexed_address_decode;
  timeunit 1ns;
  timeprecision 1ns;
  import cix_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_data;
  logic pready, pslverr, mem_req, mem_ack, busy, rd_err;
  logic [15:0] mem_addr, ea;
  logic [7:0] mem_rdata;
  logic [15:0] code_pc = 16'h0100;
  int fail_count = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  cix_addr_decode cix_addr_decode_inst (.clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
    .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata), .busy_o(busy), .ea_o(ea));
  cix_mem_model cix_mem_model_inst (.clk_i(clk), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
    .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));
  // ==========================================
  // Shared tasks
  task automatic print_verdict;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic give_up;
    fail_count++;
    print_verdict();
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) give_up();
    @(posedge clk);
  endtask
  // Busy is sampled only after the launching edge has settled
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin
      @(posedge clk);
      n++;
    end
    if (busy !== 1'b0) give_up();
  endtask
  // Places code at a fresh address, runs one decode, reads one register and checks done and busy in STATUS
  task automatic run(input logic [3:0] cond, input logic [2:0] mode, input logic [31:0] code,
                     input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
    for (int i = 0; i < 4; i++) begin
      cix_mem_model_inst.mem[code_pc + i] = code[31 - 8 * i -: 8];
    end
    apb(1'b1, `CIX_OFS_PC, {16'h0000, code_pc});
    apb(1'b1, `CIX_OFS_CTRL, {24'h000000, cond, mode, 1'b1});
    wait_idle();
    apb(1'b0, addr, 32'h0);
    check(rd_data & mask, exp);
    apb(1'b0, `CIX_OFS_STATUS, 32'h0);
    check(rd_data & 32'h0000000C, 32'h00000008);
    code_pc = code_pc + 16'h0010;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `CIX_OFS_FLAGS, 32'h0);
    check(rd_data, 32'h000000D0);
    apb(1'b0, 8'h30, 32'h0);
    check(rd_err, 32'h1);
    apb(1'b1, `CIX_OFS_EA, 32'h5);
    check(rd_err, 32'h1);
    cix_mem_model_inst.lat = 4;
    apb(1'b1, `CIX_OFS_PC, 32'h0080);
    apb(1'b1, `CIX_OFS_CTRL, 32'h1);
    apb(1'b1, `CIX_OFS_INDEX_X, 32'h5555);
    check(rd_err, 32'h1);
    wait_idle();
    apb(1'b1, `CIX_OFS_INDEX_X, 32'h1000);
    apb(1'b1, `CIX_OFS_INDEX_Y, 32'h2000);
    apb(1'b1, `CIX_OFS_STACK, 32'h3000);
    apb(1'b1, `CIX_OFS_ACC, 32'h1234);
    apb(1'b0, `CIX_OFS_ACC, 32'h0);
    check(rd_data, 32'h1234);
    cix_mem_model_inst.mem[16'h1010] = 8'hBE;
    cix_mem_model_inst.mem[16'h1011] = 8'hEF;
    cix_mem_model_inst.mem[16'h2234] = 8'hCA;
    cix_mem_model_inst.mem[16'h2235] = 8'hFE;
    run(4'h0, 3'd0, 32'hA6000000, `CIX_OFS_PC, 32'hFFFF, code_pc + 16'h1);
    run(4'h0, 3'd3, 32'hA65A0000, `CIX_OFS_EA, 32'hFFFF, 32'h005A);
    run(4'h0, 3'd3, 32'h18A67700, `CIX_OFS_STATUS, 32'hFF10, 32'hA610);
    run(4'h0, 3'd4, 32'hA6ABCD00, `CIX_OFS_EA, 32'hFFFF, 32'hABCD);
    run(4'h0, 3'd1, 32'hA6770000, `CIX_OFS_OPERAND, 32'hFFFF, 32'h0077);
    run(4'h0, 3'd2, 32'hA6123400, `CIX_OFS_OPERAND, 32'hFFFF, 32'h1234);
    run(4'h0, 3'd5, 32'hA6FE0000, `CIX_OFS_EA, 32'hFFFF, code_pc);
    run(4'h0, 3'd6, 32'hA6010000, `CIX_OFS_EA, 32'hFFFF, code_pc + 16'h0103);
    run(4'h6, 3'd5, 32'hA6100000, `CIX_OFS_STATUS, 32'h20, 32'h20);
    run(4'h7, 3'd5, 32'hA6100000, `CIX_OFS_STATUS, 32'h20, 32'h00);
    cix_mem_model_inst.lat = 0;
    run(4'h0, 3'd7, 32'hA6100000, `CIX_OFS_EA, 32'hFFFF, 32'h0FF0);
    run(4'h0, 3'd7, 32'hA64F0000, `CIX_OFS_EA, 32'hFFFF, 32'h200F);
    run(4'h0, 3'd7, 32'hA6810000, `CIX_OFS_EA, 32'hFFFF, 32'h3001);
    run(4'h0, 3'd7, 32'hA6C00000, `CIX_OFS_EA, 32'hFFFF, code_pc + 16'h2);
    run(4'h0, 3'd7, 32'hA6E1FF00, `CIX_OFS_EA, 32'hFFFF, 32'h0FFF);
    run(4'h0, 3'd7, 32'hA6F80500, `CIX_OFS_EA, 32'hFFFF, code_pc + 16'h8);
    run(4'h0, 3'd7, 32'hA6E1FF00, `CIX_OFS_OPERAND, 32'hFFFF, 32'h03E1);
    run(4'h0, 3'd7, 32'hA6F21234, `CIX_OFS_EA, 32'hFFFF, 32'h4234);
    run(4'h0, 3'd7, 32'hA6E30010, `CIX_OFS_EA, 32'hFFFF, 32'hBEEF);
    run(4'h0, 3'd7, 32'hA6E40000, `CIX_OFS_EA, 32'hFFFF, 32'h1012);
    run(4'h0, 3'd7, 32'hA6ED0000, `CIX_OFS_EA, 32'hFFFF, 32'h2034);
    run(4'h0, 3'd7, 32'hA6F60000, `CIX_OFS_EA, 32'hFFFF, 32'h4234);
    run(4'h0, 3'd7, 32'hA6E70000, `CIX_OFS_EA, 32'hFFFF, 32'hCAFE);
    run(4'h0, 3'd7, 32'hA6200000, `CIX_OFS_EA, 32'hFFFF, 32'h1001);
    run(4'h0, 3'd7, 32'hA6780000, `CIX_OFS_EA, 32'hFFFF, 32'h2000);
    run(4'h0, 3'd7, 32'hA6A70000, `CIX_OFS_STACK, 32'hFFFF, 32'h3008);
    apb(1'b0, `CIX_OFS_INDEX_Y, 32'h0);
    check(rd_data, 32'h1FF8);
    check({16'h0000, ea}, 32'h3008);
    print_verdict();
  end
endmodule // tb_cpu_indexed_address_decode
`default_nettype wire
